// *** rtl/upfss_pkg.sv ***
// Package of constants and types for the UART pin function and strap select block
`default_nettype none
package upfss_pkg;
    // Pin function control bit that hands the modem pins to general I/O
    localparam int unsigned MODEM_GPIO_BIT     = 1;
    localparam int unsigned GPIO_WIDTH         = 8;
    // Reset pulse figure and its length in core clock cycles (least time, rounded up)
    localparam int unsigned RESET_PULSE_NS     = 40;
    localparam int unsigned CLK_PERIOD_NS      = 50;
    localparam int unsigned RESET_PULSE_CYCLES =
        (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Reset values
    localparam logic        TX_IDLE_UART_RST   = 1'h1;
    localparam logic        RTS_N_RST          = 1'h1;
    localparam logic        STRAP_RST          = 1'h1;
    localparam logic [7:0]  GPIO_RST           = 8'h00;
    // Synchroniser idle levels: straps, receive, CTS and chip select high
    localparam logic [19:0] PIN_IDLE_RST       = 20'h4003F;
    // Strap capture sequence
    typedef enum logic [1:0] {
        UPFSS_ST_WAIT,
        UPFSS_ST_SETTLE,
        UPFSS_ST_SYNC,
        UPFSS_ST_HELD
    } upfss_strap_e;
    // Host interface flavour
    typedef enum logic {
        UPFSS_HOST_SPI,
        UPFSS_HOST_I2C
    } upfss_host_e;
endpackage : upfss_pkg
`default_nettype wire

// *** rtl/upfss_sync_if.sv ***
// Interface that carries synchronised pin levels from the synchroniser to the mux
`default_nettype none
interface upfss_sync_if;
    logic [19:0] lvl; // Synchronised pin levels
    modport src (output lvl);
    modport dst (input  lvl);
endinterface : upfss_sync_if
`default_nettype wire

// *** rtl/upfss_sync.sv ***
// Two flip-flop synchroniser for all pin inputs
`default_nettype none
module upfss_sync (
    input  wire logic        clk,     // Core clock
    input  wire logic        rst_n,   // Asynchronous reset, active low
    input  wire logic [19:0] pins,    // Raw pin levels
    input  wire logic [19:0] rst_val, // Constant levels while in reset
    upfss_sync_if.src        sync     // Synchronised levels
);
    logic [19:0] meta_q;
    logic [19:0] meta_d;
    logic [19:0] lvl_q;
    logic [19:0] lvl_d;

    // First stage feeds only the second stage; levels are stored relative to idle
    always_comb begin
        meta_d = pins ^ rst_val;
        lvl_d  = meta_q;
    end

    // Reset clears both stages, which read back as the constant idle levels so downstream logic sees quiet pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 20'h00000;
            lvl_q  <= 20'h00000;
        end else begin
            meta_q <= meta_d;
            lvl_q  <= lvl_d;
        end
    end

    assign sync.lvl = lvl_q ^ rst_val;
endmodule : upfss_sync
`default_nettype wire

// *** rtl/upfss_top.sv ***
// Pin function selection and strap capture for a two channel serial bridge
//
// What this block and the host model do
// [R1] Select pin high picks I2C, low SPI
// [R2] Host idles serial clock per chosen interface
// [R3] Infrared strap chooses plain or infrared data pins
// [R4] Half-duplex strap makes RTS RS-485 direction control
// [R5] Reset low beyond 40 ns restores everything
// [R6] In reset, transmit idles, receive ignored
// [R7] Interrupt only pulled low, never driven high
// [R8] Address-zero pin: SPI chip select or address
// [R9] Address-one pin: SPI data in or address
// [R10] CTS gates transmit or reads as input
// [R11] RTS from flow control, direction, or software
// [R12] Modem pins become GPIO under control bit
// [R13] Direction output high receive, low transmit
// [R14] Far end idles receive per mode
// [R15] Straps latched once at reset release
`default_nettype none
module upfss_top (
    input  wire logic       CORE_CLK,           // Core clock, 20 MHz
    input  wire logic       RESET_N,            // Asynchronous reset, active low
    input  wire logic       HOST_SELECT,        // High I2C-style, low SPI
    input  wire logic       SERIAL_CLK,         // Host serial clock pin
    input  wire logic       ADDR0_OR_CHIP_SELECT_N, // Address 0 or SPI select
    input  wire logic       ADDR1_OR_SERIAL_IN, // Address 1 or SPI data in
    input  wire logic       INFRARED_MODE_STRAP_N, // Infrared strap, low for IR
    input  wire logic       HALFDUPLEX_DIR_STRAP_N, // Half-duplex strap, low for RS-485
    input  wire logic [1:0] RX_PIN,             // Receive pins, [0] A, [1] B
    input  wire logic [1:0] CLEAR_TO_SEND_IN_N, // Clear-to-send pins, [0] A, [1] B
    input  wire logic [7:0] GPIO_IN,            // Shared modem/GPIO pin levels
    input  wire logic [1:0] CORE_TX_DATA,       // Serialised data from the UART cores
    input  wire logic [1:0] CORE_IR_TX,         // Infrared encoder output from cores
    input  wire logic [1:0] CORE_TX_BUSY,       // Transmitter holds data, per channel
    input  wire logic [1:0] CORE_RX_FLOW_RTS_N, // Receive flow control request
    input  wire logic [1:0] AUTO_RTS_EN,        // Auto RTS flow control enable
    input  wire logic [1:0] AUTO_CTS_EN,        // Auto CTS flow control enable
    input  wire logic [1:0] DIR_INVERT,         // Invert RS-485 direction polarity
    input  wire logic [1:0] SW_RTS_N,           // Software RTS level
    input  wire logic [1:0] CORE_MODEM_DTR_N,   // Terminal-ready from cores, [0] A, [1] B
    input  wire logic [7:0] PIN_FUNCTION_CONTROL, // Pin function control register
    input  wire logic [7:0] PIN_DIRECTION_SELECT, // GPIO direction, 1 output
    input  wire logic [7:0] GPIO_OUT_VAL,       // GPIO output values
    input  wire logic       CORE_IRQ_PEND,      // Any interrupt pending
    output logic            HOST_IS_I2C,        // Host port in I2C-style mode
    output logic            SPI_SELECTED,       // SPI chip select active
    output logic            SPI_DATA_IN,        // SPI serial data in
    output logic [1:0]      I2C_ADDR_PINS,      // Address select levels, [1] A1
    output logic            SERIAL_CLK_SYNC,    // Synchronised serial clock
    output logic            INFRARED_MODE,      // Latched infrared mode
    output logic            HALFDUPLEX_MODE,    // Latched RS-485 mode
    output logic [1:0]      TX_PIN,             // Transmit pins
    output logic [1:0]      CORE_RX_DATA,       // Receive data to cores
    output logic [1:0]      CORE_CTS_OK,        // Transmit permitted
    output logic [1:0]      CTS_LEVEL,          // CTS level readable by software
    output logic [1:0]      REQUEST_TO_SEND_OUT_N, // RTS pins, [0] A, [1] B
    output logic [7:0]      GPIO_OUT,           // Shared pin output values
    output logic [7:0]      GPIO_OE_N,          // Shared pin enables, low drives
    output logic [7:0]      GPIO_LEVEL,         // Shared pin levels for software
    output logic [1:0]      CORE_MODEM_IN_N,    // [0] set-ready A, [1] carrier A
    output logic            CORE_RING_A_N,      // Ring indicator A
    output logic            IRQ_OUT,            // Interrupt pin value, always 0
    output logic            IRQ_OE_N            // Interrupt pin enable, low pulls
);
    upfss_sync_if sync_bus ();
    upfss_pkg::upfss_strap_e strap_st_q;
    upfss_pkg::upfss_strap_e strap_st_d;
    logic        ir_q;
    logic        ir_d;
    logic        hd_q;
    logic        hd_d;
    logic [19:0] pins;
    logic [19:0] rst_val;
    logic [19:0] s;
    logic        i2c_d;
    logic        sel_d;
    logic        sdi_d;
    logic [1:0]  adr_d;
    logic [1:0]  tx_d;
    logic [1:0]  rx_d;
    logic [1:0]  ctsok_d;
    logic [1:0]  rts_d;
    logic [7:0]  gout_d;
    logic [7:0]  goe_d;
    logic        gpio_mode;
    logic        sclk_q;
    logic        i2c_q;
    logic        sel_q;
    logic        sdi_q;
    logic [1:0]  adr_q;
    logic [1:0]  tx_q;
    logic [1:0]  rx_q;
    logic [1:0]  ctsok_q;
    logic [1:0]  ctsl_q;
    logic [1:0]  rts_q;
    logic [7:0]  gout_q;
    logic [7:0]  goe_q;
    logic [7:0]  glvl_q;
    logic [1:0]  mdm_q;
    logic        ring_q;
    logic        irq_oe_q;

    // Direction pin level for one channel: high receive, low transmit
    function automatic logic dir_level(input logic busy, input logic inv);
        dir_level = busy ^ ~inv; // [R13]
    endfunction : dir_level

    // ******************************************************
    // Pin synchronisation
    // ******************************************************
    // Reset-zero stages read as idle levels, so no false start bit follows reset
    assign pins = {ADDR1_OR_SERIAL_IN, ADDR0_OR_CHIP_SELECT_N, SERIAL_CLK, HOST_SELECT,
                   GPIO_IN, 2'h0, CLEAR_TO_SEND_IN_N, RX_PIN, HALFDUPLEX_DIR_STRAP_N,
                   INFRARED_MODE_STRAP_N};
    assign rst_val = upfss_pkg::PIN_IDLE_RST;

    upfss_sync u_sync (
        .clk     (CORE_CLK),
        .rst_n   (RESET_N),
        .pins    (pins),
        .rst_val (rst_val),
        .sync    (sync_bus)
    );
    assign s = sync_bus.lvl;

    // ******************************************************
    // Strap capture
    // ******************************************************
    // Wait two edges so the synchroniser holds real pin levels, then freeze
    always_comb begin
        strap_st_d = strap_st_q;
        ir_d       = ir_q;
        hd_d       = hd_q;
        unique case (strap_st_q)
            upfss_pkg::UPFSS_ST_WAIT: begin
                strap_st_d = upfss_pkg::UPFSS_ST_SETTLE;
            end
            upfss_pkg::UPFSS_ST_SETTLE: begin
                strap_st_d = upfss_pkg::UPFSS_ST_SYNC;
            end
            upfss_pkg::UPFSS_ST_SYNC: begin
                ir_d       = ~s[0]; // [R3]
                hd_d       = ~s[1]; // [R4]
                strap_st_d = upfss_pkg::UPFSS_ST_HELD;
            end
            upfss_pkg::UPFSS_ST_HELD: begin
                strap_st_d = upfss_pkg::UPFSS_ST_HELD; // [R15]
            end
        endcase
    end

    // Async reset returns strap state; the 40 ns pulse is shorter than one 50 ns clock period
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            strap_st_q <= upfss_pkg::UPFSS_ST_WAIT; // [R5]
            ir_q       <= ~upfss_pkg::STRAP_RST;
            hd_q       <= ~upfss_pkg::STRAP_RST;
        end else begin
            strap_st_q <= strap_st_d;
            ir_q       <= ir_d;
            hd_q       <= hd_d;
        end
    end

    // ******************************************************
    // Pin function mux
    // ******************************************************
    // Host pins come synchronised: [16] select, [17] clock, [18] A0, [19] A1
    assign gpio_mode = PIN_FUNCTION_CONTROL[upfss_pkg::MODEM_GPIO_BIT]; // [R12]

    always_comb begin
        i2c_d   = s[16]; // [R1]
        sel_d   = ~s[16] & ~s[18]; // [R8]
        sdi_d   = s[16] ? 1'h0 : s[19]; // [R9]
        adr_d   = s[16] ? {s[19], s[18]} : 2'h0; // [R8]
        for (int c = 0; c < 2; c++) begin
            // Infrared idles low, plain UART idles high
            tx_d[c]    = ir_q ? CORE_IR_TX[c] : CORE_TX_DATA[c]; // [R3]
            rx_d[c]    = s[2 + c];
            ctsok_d[c] = AUTO_CTS_EN[c] ? ~s[4 + c] : 1'h1; // [R10]
            if (hd_q) begin
                rts_d[c] = dir_level(CORE_TX_BUSY[c], DIR_INVERT[c]); // [R4] [R11]
            end else if (AUTO_RTS_EN[c]) begin
                rts_d[c] = CORE_RX_FLOW_RTS_N[c]; // [R11]
            end else begin
                rts_d[c] = SW_RTS_N[c]; // [R11]
            end
        end
        for (int g = 0; g < 8; g++) begin
            goe_d[g]  = ~(gpio_mode & PIN_DIRECTION_SELECT[g]); // [R12]
            gout_d[g] = GPIO_OUT_VAL[g];
        end
        // Terminal-ready pins are modem outputs unless handed to GPIO
        if (!gpio_mode) begin
            goe_d[5]  = 1'h0;
            gout_d[5] = CORE_MODEM_DTR_N[0];
            goe_d[1]  = 1'h0;
            gout_d[1] = CORE_MODEM_DTR_N[1];
        end
    end

    // Reset forces idle transmit, quiet receive and released open-drain
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            i2c_q    <= 1'h0;
            sel_q    <= 1'h0;
            sdi_q    <= 1'h0;
            adr_q    <= 2'h0;
            sclk_q   <= 1'h0;
            tx_q     <= {2{upfss_pkg::TX_IDLE_UART_RST}}; // [R6]
            rx_q     <= 2'h3; // [R6]
            ctsok_q  <= 2'h0;
            ctsl_q   <= 2'h0;
            rts_q    <= {2{upfss_pkg::RTS_N_RST}}; // [R5]
            gout_q   <= upfss_pkg::GPIO_RST;
            goe_q    <= 8'hFF;
            glvl_q   <= upfss_pkg::GPIO_RST;
            mdm_q    <= 2'h3;
            ring_q   <= 1'h1;
            irq_oe_q <= 1'h1;
        end else begin
            i2c_q    <= i2c_d;
            sel_q    <= sel_d;
            sdi_q    <= sdi_d;
            adr_q    <= adr_d;
            sclk_q   <= s[17];
            tx_q     <= tx_d;
            rx_q     <= rx_d;
            ctsok_q  <= ctsok_d;
            ctsl_q   <= s[5:4]; // [R10]
            rts_q    <= rts_d;
            gout_q   <= gout_d;
            goe_q    <= goe_d;
            glvl_q   <= s[15:8];
            mdm_q    <= gpio_mode ? 2'h3 : {s[14], s[12]}; // [R12]
            ring_q   <= gpio_mode ? 1'h1 : s[15];
            irq_oe_q <= ~CORE_IRQ_PEND; // [R7]
        end
    end

    assign HOST_IS_I2C           = i2c_q;
    assign SPI_SELECTED          = sel_q;
    assign SPI_DATA_IN           = sdi_q;
    assign I2C_ADDR_PINS         = adr_q;
    assign SERIAL_CLK_SYNC       = sclk_q;
    assign INFRARED_MODE         = ir_q;
    assign HALFDUPLEX_MODE       = hd_q;
    assign TX_PIN                = tx_q;
    assign CORE_RX_DATA          = rx_q;
    assign CORE_CTS_OK           = ctsok_q;
    assign CTS_LEVEL             = ctsl_q;
    assign REQUEST_TO_SEND_OUT_N = rts_q;
    assign GPIO_OUT              = gout_q;
    assign GPIO_OE_N             = goe_q;
    assign GPIO_LEVEL            = glvl_q;
    assign CORE_MODEM_IN_N       = mdm_q;
    assign CORE_RING_A_N         = ring_q;
    assign IRQ_OUT               = 1'h0; // [R7]
    assign IRQ_OE_N              = irq_oe_q;
endmodule : upfss_top
`default_nettype wire

// *** testbench/upfss_monitor.sv ***
// Checker of pin function and strap behaviour at the top ports
`default_nettype none
module upfss_monitor (
    input wire logic       CORE_CLK,               // Core clock
    input wire logic       RESET_N,                // Reset, active low
    input wire logic       HOST_SELECT,            // Interface select
    input wire logic       ADDR0_OR_CHIP_SELECT_N, // Address 0 or select
    input wire logic       ADDR1_OR_SERIAL_IN,     // Address 1 or data
    input wire logic [1:0] CORE_TX_BUSY,           // Transmitter busy
    input wire logic [1:0] AUTO_RTS_EN,            // Auto RTS enable
    input wire logic [1:0] DIR_INVERT,             // Direction inversion
    input wire logic [1:0] SW_RTS_N,               // Software RTS
    input wire logic [7:0] PIN_FUNCTION_CONTROL,   // Pin function control
    input wire logic [7:0] PIN_DIRECTION_SELECT,   // GPIO direction
    input wire logic       CORE_IRQ_PEND,          // Interrupt pending
    input wire logic       HOST_IS_I2C,            // Host mode
    input wire logic       SPI_SELECTED,           // Chip select seen
    input wire logic       SPI_DATA_IN,            // SPI data
    input wire logic [1:0] I2C_ADDR_PINS,          // Address levels
    input wire logic       INFRARED_MODE,          // Latched IR mode
    input wire logic       HALFDUPLEX_MODE,        // Latched RS-485 mode
    input wire logic [1:0] TX_PIN,                 // Transmit pins
    input wire logic [1:0] CORE_RX_DATA,           // Receive data
    input wire logic [1:0] REQUEST_TO_SEND_OUT_N,  // RTS pins
    input wire logic [7:0] GPIO_OE_N,              // GPIO enables
    input wire logic       IRQ_OUT,                // Interrupt value
    input wire logic       IRQ_OE_N                // Interrupt enable
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] up_q;
    logic       up;
    // ****************
    // Settle counter
    // ****************
    // Straps and pin synchronisers need a few edges after release
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            up_q <= 3'h0;
        end else if (up_q != 3'h7) begin
            up_q <= up_q + 3'h1;
        end
    end
    assign up = (up_q == 3'h7);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    // Host pin decoding, three registers deep
    // Host pins pass two synchroniser stages and the output register: three deep
    host_mode_a: assert property (up |-> HOST_IS_I2C == $past(HOST_SELECT, 3))
        else $error("host mode wrong");
    chip_sel_a: assert property (up |-> SPI_SELECTED ==
        (!$past(HOST_SELECT, 3) && !$past(ADDR0_OR_CHIP_SELECT_N, 3)) && I2C_ADDR_PINS ==
        ($past(HOST_SELECT, 3) ?
        {$past(ADDR1_OR_SERIAL_IN, 3), $past(ADDR0_OR_CHIP_SELECT_N, 3)} : 2'h0))
        else $error("address pin decode wrong");
    spi_data_a: assert property (up |-> SPI_DATA_IN ==
        (!$past(HOST_SELECT, 3) && $past(ADDR1_OR_SERIAL_IN, 3)))
        else $error("SPI data wrong");
    irq_pull_a: assert property (up |-> !IRQ_OUT && IRQ_OE_N == !$past(CORE_IRQ_PEND))
        else $error("interrupt pin wrong");
    // Checked in reset too, so the default disable is switched off here
    reset_idle_a: assert property (disable iff (1'b0) !RESET_N |->
        TX_PIN == 2'h3 && CORE_RX_DATA == 2'h3 && IRQ_OE_N) else $error("reset levels wrong");
    strap_hold_a: assert property (up |->
        $stable(INFRARED_MODE) && $stable(HALFDUPLEX_MODE)) else $error("strap mode changed");
    dir_ctrl_a: assert property (up && HALFDUPLEX_MODE |-> REQUEST_TO_SEND_OUT_N[0] ==
        ($past(DIR_INVERT[0]) ^ !$past(CORE_TX_BUSY[0]))) else $error("direction wrong");
    rts_sw_a: assert property (up && !HALFDUPLEX_MODE && !$past(AUTO_RTS_EN[0]) |->
        REQUEST_TO_SEND_OUT_N[0] == $past(SW_RTS_N[0])) else $error("software RTS wrong");
    gpio_dir_a: assert property (up && $past(PIN_FUNCTION_CONTROL[1]) |->
        GPIO_OE_N == ~$past(PIN_DIRECTION_SELECT)) else $error("GPIO enable wrong");
    cover property (up && HALFDUPLEX_MODE);
    cover property (up && INFRARED_MODE);
    cover property (SPI_SELECTED);
    cover property (!IRQ_OE_N);
endmodule : upfss_monitor
`default_nettype wire

// *** testbench/upfss_host_model.sv ***
// Model of the host clock pin and the far end receive idle level
`default_nettype none
module upfss_host_model (
    input  wire logic       i2c,   // Host uses the I2C-style bus
    input  wire logic       ir,    // Far end in infrared mode
    input  wire logic       frame, // Transfer in progress
    output logic            sclk,  // Serial clock pin
    output logic [1:0]      rx     // Idle receive levels
);
    timeunit 1ns;
    timeprecision 1ns;
    // Clock rests at the bus idle level and runs only inside frames
    initial forever begin
        sclk = i2c;
        @(i2c or frame);
        // Toggle only while the frame still stands, so no stray edge follows its end
        while (frame) begin
            #200;
            if (frame) begin
                sclk = ~sclk;
            end
        end
    end
    // Wrong idle level would look like a start bit
    assign rx = ir ? 2'h0 : 2'h3;
endmodule : upfss_host_model
`default_nettype wire

// *** testbench/upfss_top_tb_top.sv ***
// Testbench top for the pin function and strap select block
`default_nettype none
module upfss_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic CORE_CLK, RESET_N, HOST_SELECT, SERIAL_CLK, ADDR0_OR_CHIP_SELECT_N, frame;
    logic ADDR1_OR_SERIAL_IN, INFRARED_MODE_STRAP_N, HALFDUPLEX_DIR_STRAP_N, CORE_IRQ_PEND;
    logic [1:0] RX_PIN, CLEAR_TO_SEND_IN_N, CORE_TX_DATA, CORE_IR_TX, CORE_TX_BUSY, far_rx;
    logic [1:0] CORE_RX_FLOW_RTS_N, AUTO_RTS_EN, AUTO_CTS_EN, DIR_INVERT, SW_RTS_N;
    logic [1:0] CORE_MODEM_DTR_N, I2C_ADDR_PINS, TX_PIN, CORE_RX_DATA, CORE_CTS_OK;
    logic [1:0] CTS_LEVEL, REQUEST_TO_SEND_OUT_N, CORE_MODEM_IN_N;
    logic [7:0] GPIO_IN, PIN_FUNCTION_CONTROL, PIN_DIRECTION_SELECT, GPIO_OUT_VAL;
    logic [7:0] GPIO_OUT, GPIO_OE_N, GPIO_LEVEL;
    logic HOST_IS_I2C, SPI_SELECTED, SPI_DATA_IN, SERIAL_CLK_SYNC, INFRARED_MODE;
    logic HALFDUPLEX_MODE, CORE_RING_A_N, IRQ_OUT, IRQ_OE_N;
    int num_errors;
    int n_tests;
    upfss_top dut (.*);
    upfss_host_model host (.i2c(HOST_SELECT), .ir(INFRARED_MODE), .frame(frame),
        .sclk(SERIAL_CLK), .rx(far_rx));
    // ****************
    // Clock and helpers
    // ****************
    initial begin
        CORE_CLK = 1'h0;
        forever #25 CORE_CLK = ~CORE_CLK;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge CORE_CLK);
    endtask : tick
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    // ****************
    // Scenarios
    // ****************
    // Straps low at power-up, then moved: modes must not follow
    task automatic t_power_up;
        tick(12);
        chk({TX_PIN, REQUEST_TO_SEND_OUT_N, CORE_RX_DATA, IRQ_OE_N, HOST_IS_I2C}, 8'hFE);
        RESET_N = 1'h1;
        tick(6);
        chk(8'({INFRARED_MODE, HALFDUPLEX_MODE}), 8'h03);
        {INFRARED_MODE_STRAP_N, HALFDUPLEX_DIR_STRAP_N} = 2'h3;
        CORE_IR_TX = 2'h2;
        CORE_TX_DATA = 2'h1;
        tick(6);
        chk(8'({INFRARED_MODE, HALFDUPLEX_MODE}), 8'h03);
        chk(8'(TX_PIN), 8'h02);
        $display("power-up straps done");
    endtask : t_power_up
    // Direction output over all busy and inversion settings
    task automatic t_rs485_dir;
        for (int i = 0; i < 4; i++) begin
            DIR_INVERT = {2{i[1]}};
            CORE_TX_BUSY = {2{i[0]}};
            tick(2);
            chk(8'(REQUEST_TO_SEND_OUT_N), 8'({2{i[1] ^ ~i[0]}}));
        end
        $display("direction control done");
    endtask : t_rs485_dir
    // One cycle reset pulse mid-run; straps sampled again, now high
    task automatic t_reset_pulse;
        RESET_N = 1'h0;
        #20;
        chk({TX_PIN, REQUEST_TO_SEND_OUT_N, CORE_RX_DATA, IRQ_OE_N, HOST_IS_I2C}, 8'hFE);
        chk(GPIO_OE_N, 8'hFF);
        tick(1);
        RESET_N = 1'h1;
        tick(6);
        chk(8'({INFRARED_MODE, HALFDUPLEX_MODE}), 8'h00);
        chk(8'(TX_PIN), 8'h01);
        RX_PIN = far_rx & 2'h2;
        tick(4);
        chk(8'(CORE_RX_DATA), 8'h02);
        $display("reset pulse done");
    endtask : t_reset_pulse
    task automatic t_rts_source;
        {AUTO_RTS_EN, CORE_RX_FLOW_RTS_N, SW_RTS_N} = 6'h36;
        tick(2);
        chk(8'(REQUEST_TO_SEND_OUT_N), 8'h01);
        AUTO_RTS_EN = 2'h0;
        tick(2);
        chk(8'(REQUEST_TO_SEND_OUT_N), 8'h02);
        $display("RTS sources done");
    endtask : t_rts_source
    // Both host flavours, then a clocked frame in SPI mode
    task automatic t_host_pins;
        int hi;
        tick(4);
        chk(8'({HOST_IS_I2C, SPI_SELECTED, SPI_DATA_IN, I2C_ADDR_PINS, SERIAL_CLK_SYNC}),
            8'h23);
        {HOST_SELECT, ADDR0_OR_CHIP_SELECT_N, ADDR1_OR_SERIAL_IN} = 3'h1;
        tick(4);
        chk(8'({HOST_IS_I2C, SPI_SELECTED, SPI_DATA_IN, I2C_ADDR_PINS, SERIAL_CLK_SYNC}),
            8'h18);
        frame = 1'h1;
        hi = 0;
        // Clock view lags the pin by three edges, so two extra samples see the last phase
        repeat (34) begin
            tick(1);
            hi += int'(SERIAL_CLK_SYNC === 1'h1);
        end
        frame = 1'h0;
        chk(8'(hi == 16), 8'h01);
        $display("host pins done");
    endtask : t_host_pins
    task automatic t_irq_pin;
        CORE_IRQ_PEND = 1'h1;
        tick(2);
        chk(8'({IRQ_OUT, IRQ_OE_N}), 8'h00);
        CORE_IRQ_PEND = 1'h0;
        tick(2);
        chk(8'({IRQ_OUT, IRQ_OE_N}), 8'h01);
        $display("interrupt pin done");
    endtask : t_irq_pin
    // Shared pins as GPIO, then as modem pins; CTS gating on and off
    task automatic t_gpio_cts;
        {PIN_FUNCTION_CONTROL, PIN_DIRECTION_SELECT, GPIO_IN, GPIO_OUT_VAL} = 32'h02F0A53C;
        {AUTO_CTS_EN, CLEAR_TO_SEND_IN_N, CORE_MODEM_DTR_N} = 6'h39;
        tick(4);
        chk(GPIO_OE_N, 8'h0F);
        chk(GPIO_LEVEL, 8'hA5);
        chk(GPIO_OUT & 8'hF0, 8'h30);
        chk(8'(CORE_CTS_OK), 8'h01);
        chk(8'(CTS_LEVEL), 8'h02);
        PIN_FUNCTION_CONTROL = 8'h00;
        AUTO_CTS_EN = 2'h0;
        tick(4);
        chk(8'({GPIO_OE_N[5], GPIO_OE_N[1], GPIO_OUT[5], GPIO_OUT[1], CORE_MODEM_IN_N,
            CORE_RING_A_N}), 8'h11);
        chk(8'(CORE_CTS_OK), 8'h03);
        $display("GPIO and CTS done");
    endtask : t_gpio_cts
    // Main sequence; inputs change only at falling edges
    initial begin
        {HOST_SELECT, ADDR0_OR_CHIP_SELECT_N, ADDR1_OR_SERIAL_IN, frame, CORE_IRQ_PEND} = 5'h18;
        {CORE_TX_DATA, CORE_IR_TX, CORE_TX_BUSY, CORE_RX_FLOW_RTS_N} = 8'h00;
        {AUTO_RTS_EN, AUTO_CTS_EN, DIR_INVERT, SW_RTS_N, CORE_MODEM_DTR_N} = 10'h000;
        {PIN_FUNCTION_CONTROL, PIN_DIRECTION_SELECT, GPIO_OUT_VAL, GPIO_IN} = 32'h0;
        {CLEAR_TO_SEND_IN_N, RX_PIN, INFRARED_MODE_STRAP_N, HALFDUPLEX_DIR_STRAP_N} = 6'h00;
        // A real falling reset edge reaches every flop before the first clock edge
        RESET_N = 1'h1;
        #1;
        RESET_N = 1'h0;
        num_errors = 0;
        n_tests = 0;
        t_power_up();
        t_rs485_dir();
        t_reset_pulse();
        t_rts_source();
        t_host_pins();
        t_irq_pin();
        t_gpio_cts();
        test_done();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        num_errors++;
        test_done();
    end
endmodule : upfss_top_tb_top
bind upfss_top upfss_monitor mon (.*);
`default_nettype wire
